// File: core/pss_pkg.sv
// constants and types shared by the program sequencer and its alu
`default_nettype none
package pss_pkg;

   // ----------------------------------------------------------------
   // widths and sizes
   // ----------------------------------------------------------------
   localparam int PC_W        = 12;
   localparam int DATA_W      = 8;
   localparam int INSTR_W     = 16;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W        = 3;
   localparam int CNT_W       = 4;
   localparam int AVS_ADDR_W  = 4;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ        = 40_000_000;
   localparam int PHASES_PER_CYCLE  = 4;

   // ----------------------------------------------------------------
   // register map (byte addresses) and field positions
   // ----------------------------------------------------------------
   localparam logic [AVS_ADDR_W-1:0] REG_PCL    = 4'h0;
   localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [AVS_ADDR_W-1:0] REG_CTRL   = 4'h8;
   localparam logic [AVS_ADDR_W-1:0] REG_ACC    = 4'hc;

   localparam int ST_C    = 0;
   localparam int ST_AC   = 1;
   localparam int ST_Z    = 2;
   localparam int ST_OV   = 3;
   localparam int ST_FULL = 4;
   localparam int CTRL_IRQ_EN = 0;

   // ----------------------------------------------------------------
   // reset values and vectors
   // ----------------------------------------------------------------
   localparam logic [PC_W-1:0]    RESET_VECTOR = 12'h000;
   localparam logic [PC_W-1:0]    IRQ_VECTOR   = 12'h004;
   localparam logic [3:0]         FLAGS_RST    = 4'h0;
   localparam logic [DATA_W-1:0]  ACC_RST      = 8'h00;
   localparam logic [INSTR_W-1:0] DUMMY_INSTR  = 16'h0000;

   // ----------------------------------------------------------------
   // instruction classes, bits 15:12 of the word
   // ----------------------------------------------------------------
   localparam logic [3:0] OP_NOP  = 4'h0;
   localparam logic [3:0] OP_ALU  = 4'h1;
   localparam logic [3:0] OP_EXT  = 4'h2;
   localparam logic [3:0] OP_JMP  = 4'h3;
   localparam logic [3:0] OP_CALL = 4'h4;
   localparam logic [3:0] OP_RET  = 4'h5;
   localparam logic [3:0] OP_INTERRUPT_RETURN_OP = 4'h6;
   localparam logic [3:0] OP_SZ   = 4'h7;
   localparam logic [3:0] OP_SNZ  = 4'h8;
   localparam logic [3:0] OP_SIZ  = 4'h9;
   localparam logic [3:0] OP_SDZ  = 4'ha;

   // ----------------------------------------------------------------
   // alu operations, bits 11:8 of an alu word
   // ----------------------------------------------------------------
   localparam logic [3:0] ALU_ADD  = 4'h0;
   localparam logic [3:0] ALU_ADC  = 4'h1;
   localparam logic [3:0] ALU_SUB  = 4'h2;
   localparam logic [3:0] ALU_SBC  = 4'h3;
   localparam logic [3:0] ALU_AND  = 4'h4;
   localparam logic [3:0] ALU_OR   = 4'h5;
   localparam logic [3:0] ALU_XOR  = 4'h6;
   localparam logic [3:0] ALU_CPL  = 4'h7;
   localparam logic [3:0] ALU_RR   = 4'h8;
   localparam logic [3:0] ALU_RRC  = 4'h9;
   localparam logic [3:0] ALU_RL   = 4'ha;
   localparam logic [3:0] ALU_RLC  = 4'hb;
   localparam logic [3:0] ALU_INC  = 4'hc;
   localparam logic [3:0] ALU_DEC  = 4'hd;
   localparam logic [3:0] ALU_MOV  = 4'he;

   typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} pss_phase_t;

endpackage
`default_nettype wire

// File: core/pss_alu.sv
// eight-bit alu with carry, half carry, zero and overflow flags
`timescale 1ns/1ps
`default_nettype none
module pss_alu (
   // operation and operands
   input  wire logic [3:0]                 i_op,
   input  wire logic [pss_pkg::DATA_W-1:0] i_a,
   input  wire logic [pss_pkg::DATA_W-1:0] i_b,
   input  wire logic                       i_cin,
   // result and flags
   output logic      [pss_pkg::DATA_W-1:0] o_y,
   output logic      [3:0]                 o_flags
);
   import pss_pkg::*;

   logic [8:0] sum;
   logic [4:0] half;
   logic       c;
   logic       ac;
   logic       ov;

   always_comb begin
      sum  = 9'h000;
      half = 5'h00;
      c    = i_cin;
      ac   = 1'b0;
      ov   = 1'b0;
      o_y  = i_a;
      case (i_op)
         ALU_ADD, ALU_ADC, ALU_INC: begin
            sum  = {1'b0, i_a} + {1'b0, (i_op == ALU_INC) ? 8'h01 : i_b}
                   + {8'h00, (i_op == ALU_ADC) & i_cin};
            half = {1'b0, i_a[3:0]} + {1'b0, (i_op == ALU_INC) ? 4'h1 : i_b[3:0]}
                   + {4'h0, (i_op == ALU_ADC) & i_cin};
            o_y  = sum[7:0];
            c    = (i_op == ALU_INC) ? i_cin : sum[8];
            ac   = half[4];
            ov   = (i_a[7] == sum[7] ^ 1'b1) & (i_op != ALU_INC ? i_a[7] == i_b[7] : ~i_a[7]);
         end
         ALU_SUB, ALU_SBC, ALU_DEC: begin
            // carry set means no borrow
            sum  = {1'b0, i_a} - {1'b0, (i_op == ALU_DEC) ? 8'h01 : i_b}
                   - {8'h00, (i_op == ALU_SBC) & ~i_cin};
            half = {1'b0, i_a[3:0]} - {1'b0, (i_op == ALU_DEC) ? 4'h1 : i_b[3:0]}
                   - {4'h0, (i_op == ALU_SBC) & ~i_cin};
            o_y  = sum[7:0];
            c    = (i_op == ALU_DEC) ? i_cin : ~sum[8];
            ac   = ~half[4];
            ov   = (i_a[7] != sum[7]) & (i_op != ALU_DEC ? i_a[7] != i_b[7] : i_a[7]);
         end
         ALU_AND: o_y = i_a & i_b;
         ALU_OR:  o_y = i_a | i_b;
         ALU_XOR: o_y = i_a ^ i_b;
         ALU_CPL: o_y = ~i_a;
         ALU_RR:  o_y = {i_a[0], i_a[7:1]};
         ALU_RL:  o_y = {i_a[6:0], i_a[7]};
         ALU_RRC: begin
            o_y = {i_cin, i_a[7:1]};
            c   = i_a[0];
         end
         ALU_RLC: begin
            o_y = {i_a[6:0], i_cin};
            c   = i_a[7];
         end
         ALU_MOV: o_y = i_b;
         default: o_y = i_a;
      endcase
      o_flags        = 4'h0;
      o_flags[ST_C]  = c;
      o_flags[ST_AC] = ac;
      o_flags[ST_Z]  = (o_y == 8'h00);
      o_flags[ST_OV] = ov;
   end

endmodule
`default_nettype wire

// File: core/pss_seq.sv
// program sequencer: phase clocks, pipelined fetch, return stack, alu
//
// Overview of operation
// RL1: four non-overlapping phases per instruction cycle
// RL2: first phase advances pc and fetches
// RL3: fetch overlaps execute, one cycle each
// RL4: flow change costs one extra cycle
// RL5: extended two cycles, branches one more
// RL6: pc increments unless flow is redirected
// RL7: jump, call, interrupt, reset load pc
// RL8: taken skip discards prefetch, runs dummy
// RL9: 12-bit pc, only low byte addressable
// RL10: low byte write jumps in page, dummy
// RL11: stack and pointer hidden from software
// RL12: call/interrupt push, returns pop pc
// RL13: reset sets stack pointer to top
// RL14: full stack holds interrupt until pop
// RL15: call on full stack drops oldest entry
// RL16: eight-bit alu result to accumulator
// RL17: alu updates status flags
// RL18: eight levels, full when eight saved
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pss_seq (
   // clock and reset
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_arst_n,
   // program memory
   output logic      [pss_pkg::PC_W-1:0]    o_pm_addr,
   output logic                             o_pm_rd,
   input  wire logic [pss_pkg::INSTR_W-1:0] i_pm_data,
   // interrupt request and acknowledge
   input  wire logic                        i_irq_req,
   output logic                             o_irq_ack,
   // status
   output logic      [3:0]                  o_phase,
   output logic      [pss_pkg::DATA_W-1:0]  o_acc,
   output logic                             o_stack_full,
   // avalon-mm slave
   input  wire logic [pss_pkg::AVS_ADDR_W-1:0] i_avs_address,
   input  wire logic                        i_avs_read,
   input  wire logic                        i_avs_write,
   input  wire logic [31:0]                 i_avs_writedata,
   input  wire logic [3:0]                  i_avs_byteenable,
   output logic      [31:0]                 o_avs_readdata,
   output logic                             o_avs_waitrequest
);
   import pss_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   pss_phase_t             phase_q;
   logic [PC_W-1:0]        pc_q;
   logic [INSTR_W-1:0]     ir_q;
   logic                   ext_q;
   logic [DATA_W-1:0]      acc_q;
   logic [3:0]             flags_q;
   logic                   irq_en_q;
   logic                   irq_pend_q;
   logic [SP_W-1:0]        sp_q;
   logic [CNT_W-1:0]       cnt_q;
   logic [PC_W-1:0]        stack_q [STACK_DEPTH];
   logic                   pcl_pend_q;
   logic [DATA_W-1:0]      pcl_val_q;
   logic                   ack_q;
   logic                   exec;
   logic                   t1;
   logic [3:0]             cls;
   logic [3:0]             alu_op;
   logic [DATA_W-1:0]      alu_y;
   logic [3:0]             alu_flags;
   logic                   acc_we;
   logic                   ext_first;
   logic                   do_jump;
   logic [PC_W-1:0]        jump_tgt;
   logic                   do_push;
   logic                   do_pop;
   logic                   skip;
   logic                   interrupt_return_op;
   logic                   irq_take;
   logic                   pcl_apply;
   logic                   flush;
   logic                   full;
   logic [SP_W-1:0]        sp_prev;
   logic                   bus_req;
   logic                   wr_ok;

   // ----------------------------------------------------------------
   // phase sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         phase_q <= PH_T1;
      end else begin
         case (phase_q)   // [RL1]
            PH_T1:   phase_q <= PH_T2;
            PH_T2:   phase_q <= PH_T3;
            PH_T3:   phase_q <= PH_T4;
            PH_T4:   phase_q <= PH_T1;
            default: phase_q <= PH_T1;
         endcase
      end
   end

   // one-hot, so no two phases are ever active together
   assign o_phase = 4'h1 << phase_q;   // [RL1]
   assign t1      = (phase_q == PH_T1);
   // the current word retires on the last phase edge
   assign exec    = (phase_q == PH_T4);   // [RL3]

   // ----------------------------------------------------------------
   // decode and execute
   // ----------------------------------------------------------------
   assign cls     = ir_q[15:12];
   assign full    = (cnt_q == CNT_W'(STACK_DEPTH));   // [RL18]
   assign sp_prev = sp_q - 3'h1;

   always_comb begin
      alu_op    = ir_q[11:8];
      acc_we    = 1'b0;
      ext_first = 1'b0;
      do_jump   = 1'b0;
      jump_tgt  = ir_q[11:0];
      do_push   = 1'b0;
      do_pop    = 1'b0;
      skip      = 1'b0;
      interrupt_return_op      = 1'b0;
      case (cls)
         OP_ALU: acc_we = 1'b1;   // [RL16]
         OP_EXT: begin
            // second pass reuses the held word, so no re-fetch happens
            if (ext_q) begin
               acc_we = 1'b1;   // [RL5]
            end else begin
               ext_first = 1'b1;   // [RL5]
            end
         end
         OP_JMP: do_jump = 1'b1;   // [RL7]
         OP_CALL: begin
            do_jump = 1'b1;   // [RL7]
            do_push = 1'b1;   // [RL12]
         end
         OP_RET, OP_INTERRUPT_RETURN_OP: begin
            do_jump  = 1'b1;
            do_pop   = 1'b1;   // [RL12]
            jump_tgt = stack_q[sp_prev];
            interrupt_return_op     = (cls == OP_INTERRUPT_RETURN_OP);
         end
         OP_SZ:  skip = (acc_q == 8'h00);   // [RL8]
         OP_SNZ: skip = (acc_q != 8'h00);   // [RL8]
         OP_SIZ, OP_SDZ: begin
            alu_op = (cls == OP_SIZ) ? ALU_INC : ALU_DEC;
            acc_we = 1'b1;
            skip   = (alu_y == 8'h00);   // [RL8]
         end
         default: acc_we = 1'b0;
      endcase
   end

   // interrupts wait out any redirect so the saved address stays exact
   assign irq_take  = exec & irq_pend_q & irq_en_q & ~full   // [RL14]
                      & ~do_jump & ~skip & ~ext_first & ~pcl_pend_q;
   assign pcl_apply = exec & pcl_pend_q & ~do_jump & ~ext_first;   // [RL10]
   assign flush     = do_jump | skip | pcl_apply | irq_take;   // [RL4]

   pss_alu u_alu (
      .i_op    (alu_op),
      .i_a     (acc_q),
      .i_b     (ir_q[7:0]),
      .i_cin   (flags_q[ST_C]),
      .o_y     (alu_y),
      .o_flags (alu_flags)
   );

   // ----------------------------------------------------------------
   // program counter and fetch
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pc_q <= RESET_VECTOR;   // [RL7]
      end else if (exec && do_jump) begin
         pc_q <= jump_tgt;   // [RL7]
      end else if (exec && irq_take) begin
         pc_q <= IRQ_VECTOR;   // [RL7]
      end else if (pcl_apply) begin
         pc_q <= {pc_q[PC_W-1:8], pcl_val_q};   // [RL9] [RL10]
      end else if (t1 && !ext_q) begin
         pc_q <= pc_q + 12'h001;   // [RL2] [RL6]
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_pm_addr <= RESET_VECTOR;
         o_pm_rd   <= 1'b0;
      end else begin
         o_pm_rd <= t1 & ~ext_q;
         if (t1 && !ext_q) begin
            o_pm_addr <= pc_q;   // [RL2]
         end
      end
   end

   // prefetched word becomes the next executing word, or a dummy
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ir_q  <= DUMMY_INSTR;
         ext_q <= 1'b0;
      end else if (exec) begin
         ext_q <= ext_first;   // [RL5]
         if (ext_first) begin
            ir_q <= ir_q;
         end else if (flush) begin
            ir_q <= DUMMY_INSTR;   // [RL4] [RL8] [RL10]
         end else begin
            ir_q <= i_pm_data;   // [RL3]
         end
      end
   end

   // ----------------------------------------------------------------
   // accumulator and status flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         acc_q <= ACC_RST;
      end else if (exec && acc_we) begin
         acc_q <= alu_y;   // [RL16]
      end
   end

   // alu wins over a software write landing on the same edge
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         flags_q <= FLAGS_RST;
      end else if (exec && acc_we) begin
         flags_q <= alu_flags;   // [RL17]
      end else if (wr_ok && i_avs_address == REG_STATUS && i_avs_byteenable[0]) begin
         flags_q <= i_avs_writedata[3:0];
      end
   end

   // ----------------------------------------------------------------
   // return stack
   // ----------------------------------------------------------------
   // pointer wraps, so a push on a full stack overwrites the oldest
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sp_q  <= 3'h0;   // [RL13]
         cnt_q <= 4'h0;   // [RL13]
      end else if (exec && (do_push || irq_take)) begin
         sp_q  <= sp_q + 3'h1;   // [RL15]
         cnt_q <= full ? cnt_q : cnt_q + 4'h1;   // [RL15] [RL18]
      end else if (exec && do_pop) begin
         sp_q  <= sp_prev;   // [RL12]
         cnt_q <= (cnt_q == 4'h0) ? cnt_q : cnt_q - 4'h1;
      end
   end

   generate
      for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_stack
         always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
               stack_q[g] <= RESET_VECTOR;
            end else if (exec && (do_push || irq_take) && sp_q == SP_W'(g)) begin
               // address of the discarded prefetch is where flow resumes
               stack_q[g] <= o_pm_addr;   // [RL12]
            end
         end
      end
   endgenerate

   assign o_stack_full = full;

   // ----------------------------------------------------------------
   // interrupt request and acknowledge
   // ----------------------------------------------------------------
   // a new request on the acknowledge edge is kept pending
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq_pend_q <= 1'b0;
         o_irq_ack  <= 1'b0;
      end else begin
         irq_pend_q <= i_irq_req | (irq_pend_q & ~irq_take);   // [RL14]
         o_irq_ack  <= irq_take;   // [RL12]
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq_en_q <= 1'b0;
      end else if (irq_take) begin
         irq_en_q <= 1'b0;
      end else if (exec && interrupt_return_op) begin
         irq_en_q <= 1'b1;
      end else if (wr_ok && i_avs_address == REG_CTRL && i_avs_byteenable[0]) begin
         irq_en_q <= i_avs_writedata[CTRL_IRQ_EN];
      end
   end

   // ----------------------------------------------------------------
   // avalon-mm slave
   // ----------------------------------------------------------------
   // one wait state per access; the stack has no address here
   assign bus_req           = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = bus_req & ~ack_q;
   assign wr_ok             = i_avs_write & ack_q;

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_avs_readdata <= 32'h0000_0000;
      end else if (i_avs_read && !ack_q) begin
         case (i_avs_address)
            REG_PCL:    o_avs_readdata <= {24'h00_0000, pc_q[7:0]};   // [RL9]
            REG_STATUS: o_avs_readdata <= {27'h000_0000, full, flags_q};
            REG_CTRL:   o_avs_readdata <= {31'h0000_0000, irq_en_q};
            REG_ACC:    o_avs_readdata <= {24'h00_0000, acc_q};
            default:    o_avs_readdata <= 32'h0000_0000;   // [RL11]
         endcase
      end
   end

   // a pending page jump waits for a quiet execute edge
   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pcl_pend_q <= 1'b0;
         pcl_val_q  <= 8'h00;
      end else if (wr_ok && i_avs_address == REG_PCL && i_avs_byteenable[0]) begin
         pcl_pend_q <= 1'b1;   // [RL10]
         pcl_val_q  <= i_avs_writedata[7:0];
      end else if (pcl_apply) begin
         pcl_pend_q <= 1'b0;
      end
   end

   assign o_acc = acc_q;

endmodule
`default_nettype wire

// File: tb/pss_seq_props.sv
// port-level assertions for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module pss_seq_props (
   // clock, reset and watched ports
   input wire logic                           i_sys_clk,
   input wire logic                           i_arst_n,
   input wire logic [pss_pkg::PC_W-1:0]       o_pm_addr,
   input wire logic                           o_pm_rd,
   input wire logic                           o_irq_ack,
   input wire logic [3:0]                     o_phase,
   input wire logic                           o_stack_full,
   input wire logic [pss_pkg::AVS_ADDR_W-1:0] i_avs_address,
   input wire logic                           i_avs_read,
   input wire logic                           i_avs_write,
   input wire logic [31:0]                    o_avs_readdata,
   input wire logic                           o_avs_waitrequest
);
   import pss_pkg::*;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   // ------------------------------------------------------------
   // sequences and properties
   // ------------------------------------------------------------
   sequence s_tail;
      o_phase == 4'h4 ##1 o_phase == 4'h8 ##1 o_phase == 4'h1;
   endsequence
   sequence s_one_wait;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   property p_onehot; $onehot(o_phase); endproperty
   property p_rotate; o_phase == 4'h2 |=> s_tail; endproperty
   property p_rd_t2; o_pm_rd |-> o_phase == 4'h2; endproperty
   property p_addr_hold; o_phase != 4'h2 |-> $stable(o_pm_addr); endproperty
   property p_rd_gap; o_pm_rd |=> !o_pm_rd [*3]; endproperty
   property p_ack_one; o_irq_ack |=> !o_irq_ack; endproperty
   property p_ack_vec; o_irq_ack |-> ##[0:4] o_pm_addr == IRQ_VECTOR; endproperty
   // full long enough that no push can be in flight
   property p_full_noack;
      o_stack_full && $past(o_stack_full, 3) |-> !o_irq_ack;
   endproperty
   property p_one_wait; $rose(i_avs_read | i_avs_write) |-> s_one_wait; endproperty
   property p_unmapped;
      i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h2 |=> o_avs_readdata == 32'h0;
   endproperty
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_onehot: assert property (p_onehot) else $error("phase not one-hot");
   a_rotate: assert property (p_rotate) else $error("phase order broken");
   a_rd_t2: assert property (p_rd_t2) else $error("fetch strobe outside T2");
   a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
   a_rd_gap: assert property (p_rd_gap) else $error("fetches too close");
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one clock");
   a_ack_vec: assert property (p_ack_vec) else $error("no vector fetch after ack");
   a_full_noack: assert property (p_full_noack) else $error("ack with full stack");
   a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind pss_seq pss_seq_props u_props (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
   .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd), .o_irq_ack(o_irq_ack), .o_phase(o_phase),
   .o_stack_full(o_stack_full), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire

// File: tb/pss_pm_model.sv
// program memory model holding the test program
`timescale 1ns/1ps
`default_nettype none
module pss_pm_model (
   // fetch side
   input  wire logic [11:0] i_addr,
   output logic      [15:0] o_data
);
   logic [15:0] mem [0:4095];
   initial begin
      foreach (mem[i]) mem[i] = 16'h0000;
      mem[12'h000] = 16'h1e00;
      mem[12'h001] = 16'h7000;
      mem[12'h002] = 16'h1eff;
      mem[12'h003] = 16'h3010;
      // service routine runs one extended word, then returns
      mem[12'h004] = 16'h2e55;
      mem[12'h005] = 16'h6000;
      mem[12'h010] = 16'h4020;
      // 90 plus f5 leaves 85 with carry out
      mem[12'h011] = 16'h10f5;
      mem[12'h012] = 16'h3012;
      mem[12'h020] = 16'h1090;
      mem[12'h021] = 16'h5000;
      // nine nested calls: the last one overwrites the oldest level
      for (int i = 0; i < 9; i++) mem[12'h040 + i] = 16'h4041 + 16'(i);
      mem[12'h049] = 16'h3049;
      mem[12'h050] = 16'h5000;
   end
   // address stands a whole cycle, so a plain lookup is enough
   assign o_data = mem[i_addr];
endmodule
`default_nettype wire

// File: tb/test_program_sequencer_stack.sv
// self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module test_program_sequencer_stack;
   import pss_pkg::*;
   logic        clk, rst_n, rd, wr, irq, pm_rd, ack, full, wait_r;
   logic [3:0]  adr, phase;
   logic [31:0] wd, rd_bus, q;
   logic [11:0] pm_addr;
   logic [15:0] pm_data;
   logic [7:0]  acc;
   int          err_total, comparisons, acks;
   logic [11:0] trace [$];
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   pss_seq dut (.i_sys_clk(clk), .i_arst_n(rst_n), .o_pm_addr(pm_addr), .o_pm_rd(pm_rd),
      .i_pm_data(pm_data), .i_irq_req(irq), .o_irq_ack(ack), .o_phase(phase), .o_acc(acc),
      .o_stack_full(full), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'h1), .o_avs_readdata(rd_bus),
      .o_avs_waitrequest(wait_r));
   pss_pm_model u_pm (.i_addr(pm_addr), .o_data(pm_data));
   always @(posedge clk) begin
      if (pm_rd === 1'b1) trace.push_back(pm_addr);
      if (ack === 1'b1) acks++;
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wait_r !== 1'b0 && n < 50);
      q = rd_bus;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         err_total++;
         report_and_stop;
      end
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_flow;
      logic [11:0] exp [12] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h010,
                                12'h011, 12'h020, 12'h021, 12'h022, 12'h011, 12'h012};
      chk("full after reset", {31'h0, full}, 32'h0);
      repeat (200) @(posedge clk);
      // a skip that failed would leave 84 here
      chk("acc", {24'h0, acc}, 32'h85);
      for (int i = 0; i < 12; i++) chk("fetch", {20'h0, trace[i]}, {20'h0, exp[i]});
      $display("test flow done");
   endtask
   task automatic t_regs;
      bus(1'b0, REG_ACC, 32'h0);
      chk("acc reg", q, 32'h85);
      bus(1'b1, REG_ACC, 32'h11);
      bus(1'b0, REG_ACC, 32'h0);
      chk("acc read-only", q, 32'h85);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("status", q, 32'h1);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", q, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_stack;
      logic [11:0] ret_to = 12'hfff;
      bus(1'b1, REG_PCL, 32'h40);
      repeat (120) @(posedge clk);
      chk("stack full", {31'h0, full}, 32'h1);
      bus(1'b1, REG_CTRL, 32'h1);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      repeat (60) @(posedge clk);
      chk("held ack", acks, 32'h0);
      // a return frees one level, which lets the held request in
      bus(1'b1, REG_PCL, 32'h50);
      for (int n = 0; n < 300 && acks == 0; n++) @(posedge clk);
      chk("ack after pop", acks, 32'h1);
      repeat (60) @(posedge clk);
      chk("full after return", {31'h0, full}, 32'h0);
      // the fetch after the service return shows the overwritten level
      foreach (trace[i]) if (trace[i] == 12'h006) ret_to = trace[i + 1];
      chk("resume after overflow", {20'h0, ret_to}, 32'h49);
      chk("extended op", {24'h0, acc}, 32'h55);
      $display("test stack done");
   endtask
   initial begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      irq = 1'b0;
      adr = 4'h0;
      wd = 32'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_flow;
      t_regs;
      t_stack;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      report_and_stop;
   end
endmodule
`default_nettype wire
